// *** verif/test_csm_config_sets.sv ***
// test_csm_config_sets: self-checking bench for the configuration set block.
// assumes: csm_pkg compiled first; bench acts as Avalon-MM master and
// drives the acquisition status levels itself.
`timescale 1ns/1ns
module test_csm_config_sets;
    localparam int unsigned WORDS = csm_pkg::CFG_WORDS;
    localparam logic [31:0] FACT  = 32'h0000_1000;

    logic                 clk;
    logic                 rst_n;
    logic [7:0]           avs_address;
    logic                 avs_read;
    logic                 avs_write;
    logic [31:0]          avs_writedata;
    logic [3:0]           avs_byteenable;
    logic [31:0]          avs_readdata;
    logic                 avs_waitrequest;
    logic                 acq_active;
    logic                 shot_pending;
    logic                 cfg_busy;
    logic [WORDS*32-1:0]  work_set;
    logic [31:0]          exp_work [WORDS];
    logic [31:0]          chan     [4][WORDS];
    int                   failures;
    int                   compares;

    csm_config_sets #(.WORDS(WORDS), .FACTORY(FACT)) i_csm_config_sets (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .acq_active(acq_active), .shot_pending(shot_pending),
        .cfg_busy(cfg_busy), .work_set(work_set));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task conclude;
        $display("comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    task check_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask : check_word

    // request held until waitrequest is sampled low, then released
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
    endtask : bus

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check_word(q, e);
    endtask : rd_chk

    function automatic logic [7:0] wa(input int i);
        return csm_pkg::OFS_WORK + 8'(4 * i);
    endfunction : wa

    // working set seen both on the port and through the register window
    task check_work;
        int n;
        n = 0;
        while (cfg_busy !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        for (int i = 0; i < WORDS; i++) begin
            check_word(work_set[32*i +: 32], exp_work[i]);
            rd_chk(wa(i), exp_work[i]);
        end
    endtask : check_work

    task fill(input logic [31:0] base);
        for (int i = 0; i < WORDS; i++) begin
            wr(wa(i), base + 32'(i));
            exp_work[i] = base + 32'(i);
        end
    endtask : fill

    task save(input logic [1:0] ch);
        wr(csm_pkg::OFS_SAVE_CH, {30'h0, ch});
        wr(csm_pkg::OFS_SAVE, 32'h0000_0001);
        if (ch != csm_pkg::FACTORY_CH) chan[ch] = exp_work;
    endtask : save

    task load(input logic [31:0] ch);
        logic ok;
        ok = ch < 4 && !acq_active && !shot_pending;
        wr(csm_pkg::OFS_LOAD_CH, ch);
        check_word({31'h0, cfg_busy}, {31'h0, ok});
        if (ok) exp_work = chan[ch[1:0]];
        check_work();
    endtask : load

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("ERROR at %0t: watchdog %08h vs %08h", $time, 1, 0);
        conclude();
    end

    initial begin
        rst_n = 1'b0; avs_address = 8'h00; avs_read = 1'b0; avs_write = 1'b0;
        avs_writedata = 32'h0; avs_byteenable = 4'hF;
        acq_active = 1'b0; shot_pending = 1'b0;
        failures = 0; compares = 0;
        for (int i = 0; i < WORDS; i++) chan[0][i] = FACT + 32'(i);
        exp_work = chan[0];
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        check_work();
        rd_chk(csm_pkg::OFS_SAVE_CH, 32'h0000_0001);
        rd_chk(csm_pkg::OFS_START_CH, 32'h0000_0000);
        rd_chk(csm_pkg::OFS_INIT, 32'h0000_0000);
        rd_chk(csm_pkg::OFS_STATUS, 32'h0000_0002);
        wr(8'h30, 32'hFFFF_FFFF);
        rd_chk(8'h30, 32'h0000_0000);
        avs_byteenable <= 4'h1;
        wr(wa(0), 32'h5555_55AA);
        avs_byteenable <= 4'hF;
        rd_chk(wa(0), {FACT[31:8], 8'hAA});
        $display("test reset_values done");

        fill(32'hA100_0000);
        save(2'h1);
        fill(32'hA200_0000);
        save(2'h2);
        fill(32'hA300_0000);
        save(2'h3);
        load(1);
        rd_chk(csm_pkg::OFS_LOAD_CH, 32'h0000_0001);
        load(3);
        fill(32'hB100_0000);
        save(2'h1);
        load(2);
        load(1);
        load(0);
        $display("test save_load done");

        fill(32'hC000_0000);
        save(2'h0);
        rd_chk(csm_pkg::OFS_STATUS, 32'h0000_0006);
        load(0);
        load(1);
        load(4);
        rd_chk(csm_pkg::OFS_STATUS, 32'h0000_0006);
        $display("test refusals done");

        fill(32'hD000_0000);
        acq_active <= 1'b1;
        @(posedge clk);
        load(2);
        rd_chk(csm_pkg::OFS_STATUS, 32'h0000_0004);
        acq_active   <= 1'b0;
        shot_pending <= 1'b1;
        @(posedge clk);
        load(3);
        shot_pending <= 1'b0;
        @(posedge clk);
        load(2);
        rd_chk(csm_pkg::OFS_STATUS, 32'h0000_0002);
        $display("test busy_camera done");

        wr(csm_pkg::OFS_START_CH, 32'h0000_0003);
        fill(32'hE000_0000);
        wr(csm_pkg::OFS_INIT, 32'h0000_0001);
        exp_work = chan[3];
        check_work();
        rd_chk(csm_pkg::OFS_INIT, 32'h0000_0000);
        $display("test initialize done");

        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        exp_work = chan[0];
        check_work();
        rd_chk(csm_pkg::OFS_START_CH, 32'h0000_0000);
        load(2);
        load(1);
        $display("test second_reset done");
        conclude();
    end
endmodule : test_csm_config_sets

// *** verilog/csm_chan_store.sv ***
// csm_chan_store: factory channel 0 (constant) plus user channels 1..3.
// assumes: user contents stand for non-volatile cells: no reset clears them.
`timescale 1ns/1ns
module csm_chan_store #(
    parameter int unsigned      WORDS   = 8,
    parameter logic [31:0]      FACTORY = 32'h0000_0000
) (
    input  wire logic   clk,
    csm_nv_if.store     nv
);
    localparam int unsigned IW = $clog2(WORDS);
    logic [31:0] mem [csm_pkg::NUM_CH*WORDS];
    logic [1:0]  ch;
    logic [31:0] rd_q;

    assign ch = nv.addr[IW+1:IW];

    // no reset: user channels survive reset and re-init
    always_ff @(posedge clk) begin
        if (nv.we && ch != csm_pkg::FACTORY_CH) begin
            mem[nv.addr] <= nv.wdata;
        end
    end

    // factory words are a constant pattern, never writable
    always_comb begin
        if (ch == csm_pkg::FACTORY_CH) begin
            rd_q = FACTORY + 32'(nv.addr[IW-1:0]);
        end else begin
            rd_q = mem[nv.addr];
        end
    end
    assign nv.rdata = rd_q;
endmodule : csm_chan_store

// *** verilog/csm_config_sets.sv ***
// csm_config_sets: working configuration set with save/load to memory
// channels, startup channel, self-clearing initialize, Avalon-MM slave.
// assumes: acq_active and shot_pending are synchronous levels from the
// acquisition logic; the bus master holds requests until waitrequest low.
`timescale 1ns/1ns

// How it works
// - every register write to the work window updates the byte-enabled bytes of the working set
// - working set is flip-flops, cleared by reset, then reloaded
// - factory set is constant storage, writes to it are dropped
// - exactly three user channels, numbered 1 to 3
// - user channels have no reset and survive reset and init
// - writing 1 to save copies all working words to the target
// - a save overwrites every word of the target channel
// - writing 1, 2 or 3 to load channel copies it into work set
// - channel 0 holds factory data and is never saved into
// - writing 0 to load channel copies factory set into work set
// - load channel writes only proceed while no acquisition and no shot pending; init and reset loads are not gated
// - after reset the startup channel, default 0, is loaded
// - initialize bit self-clears and reloads from startup channel
module csm_config_sets #(
    parameter int unsigned      WORDS   = csm_pkg::CFG_WORDS,
    parameter logic [31:0]      FACTORY = 32'h0000_1000
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic [7:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    input  wire logic [3:0]    avs_byteenable,
    output logic [31:0]        avs_readdata,
    output logic               avs_waitrequest,
    input  wire logic          acq_active,
    input  wire logic          shot_pending,
    output logic               cfg_busy,
    output logic [WORDS*32-1:0] work_set
);
    localparam int unsigned IW = $clog2(WORDS);

    // index math needs a power of two; the window must end by 0x80
    if (WORDS < 2 || WORDS > 16 || (1 << IW) != WORDS) begin : g_bad_words
        $error("WORDS must be a power of two from 2 to 16");
    end

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        csm_pkg::csm_state_t   st;
        logic [IW-1:0]         idx;
        logic [1:0]            ch;
        logic [1:0]            save_ch;
        logic [1:0]            start_ch;
        logic [1:0]            cur_ch;
        logic                  rejected;
        logic                  ack;
        logic                  wreq;
        logic                  busy;
        logic [31:0]           rdata;
        logic [WORDS*32-1:0]   work;
    } csm_regs_t;

    csm_regs_t q;
    csm_regs_t d;

    csm_nv_if #(.AW(IW+2), .DW(32)) nv ();

    csm_chan_store #(.WORDS(WORDS), .FACTORY(FACTORY)) u_store (
        .clk (clk),
        .nv  (nv)
    );

    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    function automatic logic is_user_ch(input logic [1:0] c);
        return c != csm_pkg::FACTORY_CH;
    endfunction : is_user_ch

    ////////////////////////////////////////////////////////////////////////
    logic        busy;
    logic        idle_cam;
    logic        wr;
    logic        rd;
    logic        in_work;
    logic [IW-1:0] widx;

    assign busy     = q.st != csm_pkg::CSM_IDLE;
    assign idle_cam = !acq_active && !shot_pending;
    // accesses stall while a copy runs, keeping the working set coherent
    assign wr       = avs_write && !busy && !q.ack;
    assign rd       = avs_read && !busy && !q.ack;
    assign in_work  = avs_address >= csm_pkg::OFS_WORK &&
                      avs_address < 8'(csm_pkg::OFS_WORK + 4*WORDS);
    assign widx     = IW'((avs_address - csm_pkg::OFS_WORK) >> 2);

    assign nv.we    = q.st == csm_pkg::CSM_SAVE;
    assign nv.addr  = {q.ch, q.idx};
    assign nv.wdata = q.work[q.idx*32 +: 32];

    always_comb begin
        d       = q;
        d.ack   = 1'b0;
        unique case (q.st)
            csm_pkg::CSM_IDLE: begin
                if (wr) begin
                    d.ack = 1'b1;
                    if (in_work) begin
                        d.work[widx*32 +: 32] = be_merge(
                            q.work[widx*32 +: 32], avs_writedata,
                            avs_byteenable);
                    end else begin
                        unique case (avs_address)
                            csm_pkg::OFS_INIT: begin
                                // bit self-clears: never stored
                                if (avs_writedata[csm_pkg::INIT_BIT]) begin
                                    d.ch  = q.start_ch;
                                    d.idx = '0;
                                    d.st  = csm_pkg::CSM_LOAD;
                                    d.work = '0;
                                end
                            end
                            csm_pkg::OFS_SAVE: begin
                                if (avs_writedata[csm_pkg::SAVE_BIT]) begin
                                    if (is_user_ch(q.save_ch)) begin
                                        d.ch  = q.save_ch;
                                        d.idx = '0;
                                        d.st  = csm_pkg::CSM_SAVE;
                                        d.rejected = 1'b0;
                                    end else begin
                                        d.rejected = 1'b1;
                                    end
                                end
                            end
                            csm_pkg::OFS_SAVE_CH: begin
                                if (avs_writedata[31:2] == '0) begin
                                    d.save_ch = avs_writedata[1:0];
                                end
                            end
                            csm_pkg::OFS_LOAD_CH: begin
                                if (avs_writedata[31:2] != '0) begin
                                    d.rejected = 1'b1;
                                end else if (idle_cam) begin
                                    d.ch     = avs_writedata[1:0];
                                    d.cur_ch = avs_writedata[1:0];
                                    d.idx    = '0;
                                    d.st     = csm_pkg::CSM_LOAD;
                                    d.rejected = 1'b0;
                                end else begin
                                    d.rejected = 1'b1;
                                end
                            end
                            csm_pkg::OFS_START_CH: begin
                                if (avs_writedata[31:2] == '0) begin
                                    d.start_ch = avs_writedata[1:0];
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end else if (rd) begin
                    d.ack   = 1'b1;
                    d.rdata = '0;
                    if (in_work) begin
                        d.rdata = q.work[widx*32 +: 32];
                    end else begin
                        unique case (avs_address)
                            csm_pkg::OFS_SAVE_CH:  d.rdata = 32'(q.save_ch);
                            csm_pkg::OFS_LOAD_CH:  d.rdata = 32'(q.cur_ch);
                            csm_pkg::OFS_START_CH: d.rdata = 32'(q.start_ch);
                            csm_pkg::OFS_STATUS: begin
                                d.rdata[csm_pkg::ST_IDLE_BIT] = idle_cam;
                                d.rdata[csm_pkg::ST_REJ_BIT]  = q.rejected;
                            end
                            default: d.rdata = '0;
                        endcase
                    end
                end
            end
            csm_pkg::CSM_LOAD: begin
                d.work[q.idx*32 +: 32] = nv.rdata;
                d.idx = q.idx + 1'b1;
                if (q.idx == IW'(WORDS-1)) begin
                    d.st = csm_pkg::CSM_IDLE;
                end
            end
            csm_pkg::CSM_SAVE: begin
                d.idx = q.idx + 1'b1;
                if (q.idx == IW'(WORDS-1)) begin
                    d.st = csm_pkg::CSM_IDLE;
                end
            end
            default: d.st = csm_pkg::CSM_IDLE;
        endcase
        // registered copies so the outputs leave straight from flip-flops
        d.busy = d.st != csm_pkg::CSM_IDLE;
        d.wreq = !d.ack;
    end

    // start channel register resets to its default, so the first load
    // after reset reads the factory channel
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q          <= '0;
            q.st       <= csm_pkg::CSM_LOAD;
            q.ch       <= csm_pkg::START_CH_RST;
            q.start_ch <= csm_pkg::START_CH_RST;
            q.cur_ch   <= csm_pkg::START_CH_RST;
            q.save_ch  <= csm_pkg::SAVE_CH_RST;
            q.busy     <= 1'b1;
            q.wreq     <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign avs_readdata    = q.rdata;
    assign avs_waitrequest = q.wreq;
    assign cfg_busy        = q.busy;
    assign work_set        = q.work;

    ////////////////////////////////////////////////////////////////////////
    sequence s_load_req;
        wr && avs_address == csm_pkg::OFS_LOAD_CH &&
            avs_writedata[31:2] == '0;
    endsequence

    a_load_when_idle: assert property (@(posedge clk)
        disable iff (!rst_n)
        s_load_req and idle_cam |=> q.st == csm_pkg::CSM_LOAD)
        else $error("load not started while idle");

    a_load_ignored_busy: assert property (@(posedge clk)
        disable iff (!rst_n)
        s_load_req and !idle_cam |=> $stable(q.work) && !busy)
        else $error("load taken while acquiring");

    a_save_bad_target: assert property (@(posedge clk)
        disable iff (!rst_n)
        wr && avs_address == csm_pkg::OFS_SAVE && avs_writedata[0] &&
        q.save_ch == csm_pkg::FACTORY_CH |=> !busy && q.rejected)
        else $error("save to channel 0 started");

    a_store_no_factory: assert property (@(posedge clk)
        disable iff (!rst_n)
        nv.we |-> nv.addr[IW+1:IW] != csm_pkg::FACTORY_CH)
        else $error("write into factory channel");

    // each save cycle steps the index; the run ends when it wraps to 0
    a_save_runs_all: assert property (@(posedge clk)
        disable iff (!rst_n)
        nv.we |=> q.idx == IW'($past(q.idx) + 1'b1) &&
        nv.we == (q.idx != '0))
        else $error("save length wrong");

    a_save_from_start: assert property (@(posedge clk)
        disable iff (!rst_n)
        $rose(nv.we) |-> q.idx == '0 && nv.addr[IW+1:IW] == q.save_ch)
        else $error("save began mid set");

    // sampled reset keeps the release edge, where work is still 0, out
    sequence s_copy_word;
        rst_n && q.st == csm_pkg::CSM_LOAD;
    endsequence

    a_load_copies: assert property (@(posedge clk)
        disable iff (!rst_n)
        s_copy_word |=> q.work[$past(q.idx)*32 +: 32] == $past(nv.rdata))
        else $error("load word not copied");

    a_load_bad_value: assert property (@(posedge clk)
        disable iff (!rst_n)
        wr && avs_address == csm_pkg::OFS_LOAD_CH &&
        avs_writedata[31:2] != '0 |=> !busy && q.rejected)
        else $error("out of range load accepted");

    a_ack_single: assert property (@(posedge clk)
        disable iff (!rst_n)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("acknowledge held too long");

    a_init_reload: assert property (@(posedge clk)
        disable iff (!rst_n)
        wr && avs_address == csm_pkg::OFS_INIT && avs_writedata[0] |=>
        q.st == csm_pkg::CSM_LOAD && q.ch == $past(q.start_ch))
        else $error("init did not reload startup channel");

    a_work_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr && in_work && avs_byteenable == 4'hF |=>
        q.work[$past(widx)*32 +: 32] == $past(avs_writedata))
        else $error("work write lost");

    a_save_start: assert property (@(posedge clk) disable iff (!rst_n)
        wr && avs_address == csm_pkg::OFS_SAVE && avs_writedata[0] &&
        q.save_ch != csm_pkg::FACTORY_CH |=>
        q.st == csm_pkg::CSM_SAVE ##[1:16] !busy)
        else $error("save did not run");
endmodule : csm_config_sets

// *** verilog/csm_nv_if.sv ***
// csm_nv_if: word port between the controller and channel storage.
// assumes: one clock; access completes in the cycle it is issued.
`timescale 1ns/1ns
interface csm_nv_if #(
    parameter int unsigned AW = 5,
    parameter int unsigned DW = 32
);
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport ctrl  (output we, output addr, output wdata, input rdata);
    modport store (input we, input addr, input wdata, output rdata);
endinterface : csm_nv_if

// *** verilog/csm_pkg.sv ***
// csm_pkg: register map, field layout, reset values and states of the
// configuration set / memory channel block.
// assumes: 32-bit Avalon-MM register slave, word addressing by byte offset.
package csm_pkg;
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned CFG_WORDS    = 8;
    localparam int unsigned NUM_CH       = 4;
    localparam int unsigned CH_W         = 2;
    // register byte offsets
    localparam logic [7:0]  OFS_INIT     = 8'h00;
    localparam logic [7:0]  OFS_SAVE     = 8'h04;
    localparam logic [7:0]  OFS_SAVE_CH  = 8'h08;
    localparam logic [7:0]  OFS_LOAD_CH  = 8'h0C;
    localparam logic [7:0]  OFS_START_CH = 8'h10;
    localparam logic [7:0]  OFS_STATUS   = 8'h14;
    localparam logic [7:0]  OFS_WORK     = 8'h40;
    // field positions
    localparam int unsigned INIT_BIT     = 0;
    localparam int unsigned SAVE_BIT     = 0;
    localparam int unsigned ST_BUSY_BIT  = 0;
    localparam int unsigned ST_IDLE_BIT  = 1;
    localparam int unsigned ST_REJ_BIT   = 2;
    // reset values and factory channel number
    localparam logic [1:0]  START_CH_RST = 2'h0;
    localparam logic [1:0]  SAVE_CH_RST  = 2'h1;
    localparam logic [1:0]  FACTORY_CH   = 2'h0;

    typedef enum logic [1:0] {
        CSM_IDLE = 2'b00,
        CSM_LOAD = 2'b01,
        CSM_SAVE = 2'b10
    } csm_state_t;
endpackage : csm_pkg
